// *** rtl/tpg_debounce.sv ***
// debounce filter for one synchronised pin level
module tpg_debounce #(
   parameter int COUNT = tpg_pkg::DEBOUNCE_TICKS
) (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic enable,
   input  wire logic level,
   output logic      filtered
);
   localparam int CW = $clog2(COUNT + 1);

   logic [CW-1:0] count;
   logic [CW-1:0] next_count;
   logic          next_filtered;

   // ************************************************************
   // filter
   // ************************************************************
   always_comb begin
      next_count    = '0;
      next_filtered = filtered;
      if (!enable) begin
         next_filtered = level;
      end else if (level != filtered) begin
         if (count == CW'(COUNT - 1)) begin
            next_filtered = level;
         end else begin
            next_count = count + CW'(1);
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count    <= '0;
         filtered <= 1'b0;
      end else begin
         count    <= next_count;
         filtered <= next_filtered;
      end
   end
endmodule

// *** rtl/tpg_pkg.sv ***
// package: register map, field layout, reset values and timing for the two-pin port
package tpg_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   // printed offsets are not multiples of four, so they are indices
   localparam logic [7:0]  PIN0_CONFIG_INDEX = 8'h08;
   localparam logic [7:0]  PIN1_CONFIG_INDEX = 8'h09;
   localparam logic [11:0] PIN0_CONFIG_ADDR  = {2'h0, PIN0_CONFIG_INDEX, 2'h0};
   localparam logic [11:0] PIN1_CONFIG_ADDR  = {2'h0, PIN1_CONFIG_INDEX, 2'h0};
   localparam int          ADDR_W            = 12;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int DIR_BIT   = 0;
   localparam int INVAL_BIT = 1;
   localparam int DRV_BIT   = 2;
   localparam int OUTV_BIT  = 3;
   localparam int DBEN_BIT  = 4;
   localparam int ALT_BIT   = 5;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic RST_DIR  = 1'h1;
   localparam logic RST_DRV  = 1'h0;
   localparam logic RST_OUTV = 1'h0;
   localparam logic RST_DBEN = 1'h0;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLOCK_HZ       = 10_000_000;
   localparam int DEBOUNCE_MS    = 30;
   localparam int DEBOUNCE_TICKS = CLOCK_HZ / 1000 * DEBOUNCE_MS;

   // ************************************************************
   // types
   // ************************************************************
   typedef struct packed {
      logic altEnable;
      logic debounceEnable;
      logic outputValue;
      logic driverType;
      logic direction;
   } tpg_pin_cfg_t;

   typedef struct packed {
      logic out;
      logic oe;
   } tpg_pin_drive_t;
endpackage

// *** rtl/tpg_two_pin_gpio.sv ***
// two general-purpose pins with alternate functions, behind an AHB-Lite slave
// What this block does
// - direction bit zero: output, resets to input
// - input value bit shows pin level
// - output value zero drives pin low
// - value one: push-pull high, open-drain released
// - driver type: zero open-drain, one push-pull
// - input direction never drives the pin, except pin 1 with alternate enable set
// - debounce bit adds 30ms filter
// - pin 0 alternate selects channel 0 voltage
// - pin 1 alternate drives channel 2 sequencer
// - alternate enable reset from factory straps
//
// Decided for this implementation: register access over AHB-Lite.
module tpg_two_pin_gpio #(
   parameter int DEBOUNCE_TICKS = tpg_pkg::DEBOUNCE_TICKS
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire logic [1:0]            altStrap,
   input  wire logic                  ch2SequencerOut,
   input  wire logic [1:0]            pinIn,
   output logic      [1:0]            pinOut,
   output logic      [1:0]            pinOe,
   output logic                       ch0UseAltVoltage
);
   // ************************************************************
   // state
   // ************************************************************
   tpg_pkg::tpg_pin_cfg_t   cfg [2];
   tpg_pkg::tpg_pin_cfg_t   next_cfg [2];
   tpg_pkg::tpg_pin_drive_t drive [2];
   logic [1:0]              sync1;
   logic [1:0]              sync2;
   logic [1:0]              level;
   logic                    strapDone;
   logic                    next_strapDone;
   logic                    wrPending;
   logic                    next_wrPending;
   logic                    wrPin;
   logic                    next_wrPin;
   logic [31:0]             next_hrdata;
   logic                    ch0Alt;
   logic                    next_ch0Alt;

   logic                    acc;
   logic                    hit0;
   logic                    hit1;

   assign acc       = hsel && hready && htrans[1];
   assign hit0      = haddr[11:0] == tpg_pkg::PIN0_CONFIG_ADDR;
   assign hit1      = haddr[11:0] == tpg_pkg::PIN1_CONFIG_ADDR;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ************************************************************
   // pin input and output paths
   // ************************************************************
   // two-stage synchroniser
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1 <= 2'h0;
         sync2 <= 2'h0;
      end else begin
         sync1 <= pinIn;
         sync2 <= sync1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin
         tpg_debounce #(
            .COUNT (DEBOUNCE_TICKS)
         ) tpg_debounce_inst (
            .clock    (clock),
            .rst      (rst),
            .enable   (cfg[g].debounceEnable),
            .level    (sync2[g]),
            .filtered (level[g])
         );

         always_comb begin
            drive[g].oe  = 1'b0;
            drive[g].out = 1'b0;
            if (g == 1 && cfg[g].altEnable) begin
               drive[g].oe  = 1'b1;
               drive[g].out = ch2SequencerOut;
            end else if (!cfg[g].direction) begin
               drive[g].oe  = !cfg[g].outputValue || cfg[g].driverType;
               drive[g].out = cfg[g].outputValue;
            end
         end

         assign pinOut[g] = drive[g].out;
         assign pinOe[g]  = drive[g].oe;
      end
   endgenerate

   // ************************************************************
   // registers
   // ************************************************************
   // writes land in the data phase; the strap load waits one edge after reset
   always_comb begin
      next_cfg       = cfg;
      next_strapDone = 1'b1;
      next_wrPending = acc && hwrite && (hit0 || hit1);
      next_wrPin     = hit1;
      next_hrdata    = 32'h0000_0000;
      if (!strapDone) begin
         next_cfg[0].altEnable = altStrap[0];
         next_cfg[1].altEnable = altStrap[1];
      end
      if (wrPending) begin
         next_cfg[wrPin].direction      = hwdata[tpg_pkg::DIR_BIT];
         next_cfg[wrPin].driverType     = hwdata[tpg_pkg::DRV_BIT];
         next_cfg[wrPin].outputValue    = hwdata[tpg_pkg::OUTV_BIT];
         next_cfg[wrPin].debounceEnable = hwdata[tpg_pkg::DBEN_BIT];
         next_cfg[wrPin].altEnable      = hwdata[tpg_pkg::ALT_BIT];
      end
      if (acc && !hwrite && (hit0 || hit1)) begin
         next_hrdata[tpg_pkg::DIR_BIT]  = cfg[hit1].direction;
         next_hrdata[tpg_pkg::INVAL_BIT] = level[hit1];
         next_hrdata[tpg_pkg::DRV_BIT]  = cfg[hit1].driverType;
         next_hrdata[tpg_pkg::OUTV_BIT] = cfg[hit1].outputValue;
         next_hrdata[tpg_pkg::DBEN_BIT] = cfg[hit1].debounceEnable;
         next_hrdata[tpg_pkg::ALT_BIT]  = cfg[hit1].altEnable;
      end
      next_ch0Alt = cfg[0].altEnable && level[0];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 2; i++) begin
            cfg[i].direction      <= tpg_pkg::RST_DIR;
            cfg[i].driverType     <= tpg_pkg::RST_DRV;
            cfg[i].outputValue    <= tpg_pkg::RST_OUTV;
            cfg[i].debounceEnable <= tpg_pkg::RST_DBEN;
            cfg[i].altEnable      <= 1'b0;
         end
         strapDone <= 1'b0;
         wrPending <= 1'b0;
         wrPin     <= 1'b0;
         hrdata    <= 32'h0000_0000;
         ch0Alt    <= 1'b0;
      end else begin
         cfg       <= next_cfg;
         strapDone <= next_strapDone;
         wrPending <= next_wrPending;
         wrPin     <= next_wrPin;
         hrdata    <= next_hrdata;
         ch0Alt    <= next_ch0Alt;
      end
   end

   assign ch0UseAltVoltage = ch0Alt;
endmodule

// *** test/tpg_pin_model.sv ***
// outside circuit on the two pins: pull-ups and an optional external driver
module tpg_pin_model (
   input  wire logic [1:0] pinOut,
   input  wire logic [1:0] pinOe,
   input  wire logic [1:0] extOn,
   input  wire logic [1:0] extLv,
   output logic      [1:0] pinIn
);
   // device drive wins, else outside driver, else pull-up
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pinIn[i] = pinOe[i] ? pinOut[i] : (extOn[i] ? extLv[i] : 1'b1);
      end
   end
endmodule

// *** test/tpg_two_pin_gpio_props.sv ***
// concurrent checks of the two-pin port, bound to its top
module tpg_two_pin_gpio_props (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic [1:0]  altStrap,
   input wire logic        ch2SequencerOut,
   input wire logic [1:0]  pinIn,
   input wire logic [1:0]  pinOut,
   input wire logic [1:0]  pinOe,
   input wire logic        ch0UseAltVoltage
);
   logic        wrPh, rdPh, go;
   logic [11:0] phA;
   logic [5:0]  sh0, sh1;
   // shadow of both registers, rebuilt from bus traffic
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         {wrPh, rdPh, go} <= 3'h0;
         phA <= 12'h000;
         sh0 <= 6'h01;
         sh1 <= 6'h01;
      end else begin
         wrPh <= hsel && htrans[1] && hwrite;
         rdPh <= hsel && htrans[1] && !hwrite;
         phA <= haddr[11:0];
         go <= 1'b1;
         if (!go)
            {sh1[5], sh0[5]} <= altStrap;
         if (wrPh && phA == tpg_pkg::PIN0_CONFIG_ADDR)
            sh0 <= {hwdata[5:2], 1'b0, hwdata[0]};
         if (wrPh && phA == tpg_pkg::PIN1_CONFIG_ADDR)
            sh1 <= {hwdata[5:2], 1'b0, hwdata[0]};
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_settled;
      (sh0[5] && !sh0[4] && $stable(pinIn[0])) [*5];
   endsequence
   a_input_no_drive: assert property (
      !(sh0[0] && pinOe[0]) && !(sh1[0] && !sh1[5] && pinOe[1])) else $error("input driven");
   a_low_drive: assert property (
      !sh0[0] && !sh0[3] |-> pinOe[0] && !pinOut[0]) else $error("low not driven");
   a_pin1_low: assert property (
      !sh1[0] && !sh1[5] && !sh1[3] |-> pinOe[1] && !pinOut[1])
      else $error("pin1 low not driven");
   a_high_drive: assert property (
      !sh0[0] && sh0[3] |-> pinOe[0] == sh0[2] && (pinOut[0] || !pinOe[0]))
      else $error("high drive wrong");
   a_seq_output: assert property (
      sh1[5] |-> pinOe[1] && pinOut[1] == ch2SequencerOut) else $error("sequencer out wrong");
   a_ch0_follow: assert property (
      s_settled |-> ch0UseAltVoltage == pinIn[0]) else $error("channel 0 select wrong");
   a_ch0_idle: assert property (
      !sh0[5] && !$past(sh0[5]) |-> !ch0UseAltVoltage) else $error("select without alt");
   a_sync_delay: assert property (
      s_settled ##1 ($changed(pinIn[0]) && sh0[5]) |=> $stable(ch0UseAltVoltage))
      else $error("input not synchronised");
   a_read_fields: assert property (
      rdPh && phA == tpg_pkg::PIN0_CONFIG_ADDR |->
      {hrdata[31:2], hrdata[0]} == {26'h0, sh0[5:2], sh0[0]}) else $error("read fields wrong");
endmodule
bind tpg_two_pin_gpio tpg_two_pin_gpio_props tpg_two_pin_gpio_props_inst (.clock, .rst,
   .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata, .altStrap, .ch2SequencerOut,
   .pinIn, .pinOut, .pinOe, .ch0UseAltVoltage);

// *** test/tpg_two_pin_gpio_test.sv ***
// self-checking bench for the two-pin port
module tpg_two_pin_gpio_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A0 = tpg_pkg::PIN0_CONFIG_ADDR;
   localparam logic [11:0] A1 = tpg_pkg::PIN1_CONFIG_ADDR;
   logic        clock, rst, hsel, hwrite, ch2, chAlt, rdy, resp;
   logic [1:0]  htrans, strap, oe, po, pi, extOn, extLv;
   logic [31:0] haddr, hwdata, hrdata, rdS, q;
   int          n_fail, samples_checked;
   tpg_two_pin_gpio #(.DEBOUNCE_TICKS(8)) tpg_two_pin_gpio_inst (.clock(clock), .rst(rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(resp),
      .altStrap(strap), .ch2SequencerOut(ch2), .pinIn(pi), .pinOut(po), .pinOe(oe),
      .ch0UseAltVoltage(chAlt));
   tpg_pin_model tpg_pin_model_inst (.pinOut(po), .pinOe(oe), .extOn(extOn),
      .extLv(extLv), .pinIn(pi));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   // one single transfer; read data captured at the closing edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge clock); while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (rdy !== 1'b1);
      chk("hresp", 32'h0, {31'h0, resp});
      @(negedge clock);
      q = rdS;
      @(posedge clock);
   endtask
   // waits first so the pin level has crossed the synchroniser
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
      repeat (4) @(posedge clock);
      bus(1'b0, a, 32'h0);
      chk(n, e, q);
   endtask
   task automatic t_reset;
      rd(A0, 32'h03, "pin0 rst");
      rd(A1, 32'h23, "pin1 rst");
      ch2 <= 1'b0;
      rd(A1, 32'h21, "pin1 seq");
      bus(1'b1, A1, 32'h01);
      rd(A1, 32'h03, "pin1 in");
   endtask
   task automatic t_output;
      bus(1'b1, A0, 32'h00);
      rd(A0, 32'h00, "od low");
      bus(1'b1, A0, 32'h08);
      rd(A0, 32'h0A, "od rel");
      extOn <= 2'h1;
      rd(A0, 32'h08, "ext low");
      extOn <= 2'h0;
      bus(1'b1, A0, 32'h0C);
      rd(A0, 32'h0E, "pp high");
      bus(1'b1, A0, 32'h0D);
      extOn <= 2'h1;
      rd(A0, 32'h0D, "in ign");
      bus(1'b1, 12'h028, 32'hFF);
      rd(12'h028, 32'h00, "unmapped");
      rd(A0, 32'h0D, "pin0 kept");
      bus(1'b1, A1, 32'h00);
      rd(A1, 32'h00, "pin1 low");
      bus(1'b1, A1, 32'h01);
   endtask
   // short pulse rejected, long level taken, then it selects channel 0 voltage
   task automatic t_debounce;
      bus(1'b1, A0, 32'h31);
      rd(A0, 32'h31, "db low");
      extOn <= 2'h0;
      repeat (3) @(posedge clock);
      bus(1'b0, A0, 32'h0);
      chk("db early", 32'h31, q);
      chk("alt sel", 32'h0, {31'h0, chAlt});
      extOn <= 2'h1;
      rd(A0, 32'h31, "db pulse");
      chk("alt sel", 32'h0, {31'h0, chAlt});
      extOn <= 2'h0;
      repeat (12) @(posedge clock);
      rd(A0, 32'h33, "db high");
      chk("alt sel", 32'h1, {31'h0, chAlt});
   endtask
   // reset again in mid-run with the other strap; pin 0 then steers channel 0 undebounced
   task automatic t_restrap;
      strap <= 2'h1;
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(A0, 32'h23, "pin0 strap");
      rd(A1, 32'h03, "pin1 strap");
      extOn <= 2'h1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk("alt sync", 32'h1, {31'h0, chAlt});
      repeat (2) @(negedge clock);
      chk("alt sel", 32'h0, {31'h0, chAlt});
      @(posedge clock);
      extOn <= 2'h0;
   endtask
   task automatic complete_run;
      if (n_fail == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) rdS <= hrdata;
   initial begin
      #300000;
      n_fail++;
      complete_run;
   end
   initial begin
      {rst, hsel, hwrite, ch2} = 4'h9;
      {htrans, strap, extOn, extLv} = 8'h20;
      {haddr, hwdata} = 64'h0;
      n_fail = 0;
      samples_checked = 0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_reset;
      t_output;
      t_debounce;
      t_restrap;
      complete_run;
   end
endmodule
